// [rtl/sjm_pkg.sv]
/*
 * Constants, register map and jam codes of the saddle jam monitor.
 * Assumes a 40 MHz system clock; all users qualify names fully.
 */
package sjm_pkg;
	// ***************************************************
	// Timing
	// ***************************************************
	localparam int CLK_HZ = 40000000;
	localparam int INLET_DLY_MS = 1000;
	localparam int DLV_DLY_MS = 1000;
	localparam int STITCH_MS = 500;
	localparam int INLET_DLY_CYC = CLK_HZ / 1000 * INLET_DLY_MS;
	localparam int DLV_DLY_CYC = CLK_HZ / 1000 * DLV_DLY_MS;
	localparam int STITCH_CYC = CLK_HZ / 1000 * STITCH_MS;
	// ***************************************************
	// Register map and fields
	// ***************************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_LEN = 4'h1;
	localparam logic [3:0] REG_DLV = 4'h2;
	localparam logic [3:0] REG_PPM = 4'h3;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_SINGLE = 1;
	localparam int CTRL_SIZE_LO = 2;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [15:0] LEN_RST = 16'h01a4;
	localparam logic [15:0] DLV_RST = 16'h0190;
	localparam logic [15:0] PPM_RST = 16'h0004;
	localparam logic [16:0] VERT_PATH_MM = 17'h00082;
	localparam logic [16:0] VERT_MARGIN_MM = 17'h00032;
	typedef enum logic [1:0] {SIZE_LARGE, SIZE_B4, SIZE_SMALL} sjm_size_type;
	typedef enum logic [3:0] {
		JAM_NONE, JAM_INLET_DLY, JAM_INLET_STAT, JAM_DLV_DLY,
		JAM_VERT_STAT, JAM_DLV_STAT, JAM_POWER_ON, JAM_DOOR,
		JAM_STAPLE, JAM_SADDLE, JAM_REMOVAL
	} sjm_code_type;
endpackage

// [rtl/sjm_limit.sv]
/*
 * Reloadable down-counter limit: time when tick is constant high,
 * feed distance when tick is one pulse per millimetre.
 * Assumes start, stop and tick synchronous to clk_i.
 */
`timescale 1ns/1ps
module sjm_limit #(parameter int W = 32) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic tick_i,
	input wire logic [W-1:0] limit_i,
	output logic expire_o
);
	logic armed_q;
	logic [W-1:0] cnt_q;
	wire last = (cnt_q <= W'(1));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_q <= 1'b0;
			cnt_q <= '0;
			expire_o <= 1'b0;
		end else begin
			expire_o <= 1'b0;
			if (start_i) begin // R14
				armed_q <= 1'b1;
				cnt_q <= limit_i;
			end else if (stop_i) begin
				armed_q <= 1'b0;
			end else if (armed_q && tick_i) begin
				if (last) begin
					armed_q <= 1'b0;
					expire_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q - W'(1);
				end
			end
		end
	end

	property p_expire;
		@(posedge clk_i) disable iff (rst_i)
		armed_q && tick_i && last && !start_i && !stop_i |=> expire_o;
	endproperty
	a_expire: assert property (p_expire) // R14
		else $error("limit reached without expiry");
	property p_quiet;
		@(posedge clk_i) disable iff (rst_i)
		!armed_q || stop_i || start_i |=> !expire_o;
	endproperty
	a_quiet: assert property (p_quiet) // R14
		else $error("expiry while not armed");
endmodule

// [rtl/sjm_stitch.sv]
/*
 * Staple jam check for one stitcher: home sensor timing against
 * motor direction. Assumes inputs synchronous to clk_i.
 */
`timescale 1ns/1ps
module sjm_stitch #(parameter int WIN = sjm_pkg::STITCH_CYC) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cw_i,
	input wire logic ccw_i,
	input wire logic home_i,
	output logic jam_o
);
	logic home_q, ccw_q, cw_arm_q, ccw_arm_q;
	logic [31:0] cw_cnt_q, ccw_cnt_q;
	wire home_rise = home_i && !home_q;
	wire home_fall = !home_i && home_q;
	wire ccw_start = ccw_i && !ccw_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			home_q <= 1'b0;
			ccw_q <= 1'b0;
			cw_arm_q <= 1'b0;
			ccw_arm_q <= 1'b0;
			cw_cnt_q <= 32'h0;
			ccw_cnt_q <= 32'h0;
			jam_o <= 1'b0;
		end else begin
			home_q <= home_i;
			ccw_q <= ccw_i;
			jam_o <= 1'b0;
			if (cw_i && home_fall) begin // R10
				cw_arm_q <= 1'b1;
				cw_cnt_q <= WIN;
			end else if (cw_arm_q) begin
				if (home_rise) begin
					cw_arm_q <= 1'b0;
				end else if (cw_cnt_q <= 32'h1) begin
					cw_arm_q <= 1'b0;
					jam_o <= 1'b1;
				end else begin
					cw_cnt_q <= cw_cnt_q - 32'h1;
				end
			end
			if (ccw_start) begin // R11
				ccw_arm_q <= 1'b1;
				ccw_cnt_q <= WIN;
			end else if (ccw_arm_q) begin
				if (home_rise) begin
					ccw_arm_q <= 1'b0;
					jam_o <= 1'b1;
				end else if (ccw_cnt_q <= 32'h1) begin
					ccw_arm_q <= 1'b0;
				end else begin
					ccw_cnt_q <= ccw_cnt_q - 32'h1;
				end
			end
		end
	end

	property p_ccw;
		@(posedge clk_i) disable iff (rst_i)
		ccw_arm_q && !ccw_start && home_rise |=> jam_o;
	endproperty
	a_ccw: assert property (p_ccw) // R11
		else $error("home within ccw window not flagged");
	property p_cw;
		@(posedge clk_i) disable iff (rst_i)
		cw_arm_q && !(cw_i && home_fall) && !home_rise
			&& cw_cnt_q == 32'h1 |=> jam_o;
	endproperty
	a_cw: assert property (p_cw) // R10
		else $error("cw home timeout not flagged");
endmodule

// [rtl/sjm_monitor.sv]
/*
 * Saddle jam monitor top: sensor timing checks, jam latch with code,
 * door-close recheck and a small register port.
 * Assumes all sensor inputs synchronous and active high (paper present,
 * cover open, motor running); host reads STAT or watches JAM_O.
 */
//
// Function
// [R01] Every detected jam is reported to the host on the jam output.
// [R02] Inlet delay jam: first sensor not on within timeout after inlet.
// [R03] Inlet stationary jam: sensors still on after 1.5 paper lengths.
// [R04] Paper size picks checked sensors; single detection checks one.
// [R05] Delivery delay jam: delivery sensor late after pusher top.
// [R06] Vertical path still on after half length minus 130 plus 50 mm.
// [R07] Delivery sensor still on after fixed feed from its activation.
// [R08] Any paper sensor showing paper at power-on is a jam; the code checks only the three paper, vertical path and delivery sensors.
// [R09] Any cover open during operation is a jam.
// [R10] Clockwise stitcher: home must return within 0.5 s of leaving.
// [R11] Counterclockwise stitcher: home active within 0.5 s is a jam.
// [R12] Positioning plate sensor off at push start is a jam.
// [R13] On doors closing, paper on vertical path reasserts the jam.
// [R14] Distances count motor pulses in mm; times count cycles.
// [R15] Jam and code hold until the door-close recheck finds path clear.
`timescale 1ns/1ps
module sjm_monitor #(
	parameter int INLET_DLY_CYC = sjm_pkg::INLET_DLY_CYC,
	parameter int DLV_DLY_CYC = sjm_pkg::DLV_DLY_CYC,
	parameter int STITCH_CYC = sjm_pkg::STITCH_CYC
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O,
	input wire logic FINISHER_INLET_SENSOR_I,
	input wire logic FIRST_PAPER_SENSOR_I,
	input wire logic SECOND_PAPER_SENSOR_I,
	input wire logic THIRD_PAPER_SENSOR_I,
	input wire logic VERTICAL_PATH_SENSOR_I,
	input wire logic DELIVERY_SENSOR_I,
	input wire logic PUSHER_TOP_SENSOR_I,
	input wire logic POSITIONING_PLATE_PAPER_SENSOR_I,
	input wire logic PUSH_START_I,
	input wire logic FRONT_DOOR_SENSOR_I,
	input wire logic OUTLET_COVER_SENSOR_I,
	input wire logic INLET_COVER_SENSOR_I,
	input wire logic DRIVE_CLK_I,
	input wire logic FRONT_STITCHER_MOTOR_CW_I,
	input wire logic FRONT_STITCHER_MOTOR_CCW_I,
	input wire logic REAR_STITCHER_MOTOR_CW_I,
	input wire logic REAR_STITCHER_MOTOR_CCW_I,
	input wire logic FRONT_STITCHER_HOME_SENSOR_I,
	input wire logic REAR_STITCHER_HOME_SENSOR_I,
	output logic JAM_O,
	output logic [3:0] JAM_CODE_O
);
	// ***************************************************
	// Register port
	// ***************************************************
	logic [3:0] ctrl_q;
	logic [15:0] len_q, dlv_q, ppm_q;

	wire run = ctrl_q[sjm_pkg::CTRL_RUN];
	wire single = ctrl_q[sjm_pkg::CTRL_SINGLE];
	wire [1:0] size = ctrl_q[sjm_pkg::CTRL_SIZE_LO +: 2];
	wire wr_ctrl = WR_I && ADDR_I == sjm_pkg::REG_CTRL;
	wire wr_len = WR_I && ADDR_I == sjm_pkg::REG_LEN;
	wire wr_dlv = WR_I && ADDR_I == sjm_pkg::REG_DLV;
	wire wr_ppm = WR_I && ADDR_I == sjm_pkg::REG_PPM;
	wire [15:0] stat_word = {11'h000, JAM_O, JAM_CODE_O};
	wire [15:0] rd_mux =
		ADDR_I == sjm_pkg::REG_CTRL ? {12'h000, ctrl_q} :
		ADDR_I == sjm_pkg::REG_LEN ? len_q :
		ADDR_I == sjm_pkg::REG_DLV ? dlv_q :
		ADDR_I == sjm_pkg::REG_PPM ? ppm_q :
		ADDR_I == sjm_pkg::REG_STAT ? stat_word : 16'h0000;

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			ctrl_q <= sjm_pkg::CTRL_RST;
			len_q <= sjm_pkg::LEN_RST;
			dlv_q <= sjm_pkg::DLV_RST;
			ppm_q <= sjm_pkg::PPM_RST;
			RDATA_O <= 16'h0000;
		end else begin
			if (wr_ctrl) ctrl_q <= WDATA_I[3:0];
			if (wr_len) len_q <= WDATA_I;
			if (wr_dlv) dlv_q <= WDATA_I;
			if (wr_ppm) ppm_q <= WDATA_I;
			RDATA_O <= RD_I ? rd_mux : 16'h0000;
		end
	end

	// ***************************************************
	// Edges and feed-distance tick
	// ***************************************************
	logic inlet_q, first_q, vert_q, dlv_s_q, top_q, drv_q;
	logic mm_tick_q, pon_q;
	logic [15:0] ppm_cnt_q;

	wire inlet_rise = FINISHER_INLET_SENSOR_I && !inlet_q;
	wire first_rise = FIRST_PAPER_SENSOR_I && !first_q;
	wire vert_fall = !VERTICAL_PATH_SENSOR_I && vert_q;
	wire dlv_rise = DELIVERY_SENSOR_I && !dlv_s_q;
	wire dlv_fall = !DELIVERY_SENSOR_I && dlv_s_q;
	wire top_rise = PUSHER_TOP_SENSOR_I && !top_q;
	wire drv_rise = DRIVE_CLK_I && !drv_q;
	// A pulses-per-mm of zero behaves as one
	wire mm_done = (ppm_cnt_q + 16'h0001) >= ppm_q;

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			inlet_q <= 1'b0;
			first_q <= 1'b0;
			vert_q <= 1'b0;
			dlv_s_q <= 1'b0;
			top_q <= 1'b0;
			drv_q <= 1'b0;
			mm_tick_q <= 1'b0;
			ppm_cnt_q <= 16'h0000;
			pon_q <= 1'b1;
		end else begin
			inlet_q <= FINISHER_INLET_SENSOR_I;
			first_q <= FIRST_PAPER_SENSOR_I;
			vert_q <= VERTICAL_PATH_SENSOR_I;
			dlv_s_q <= DELIVERY_SENSOR_I;
			top_q <= PUSHER_TOP_SENSOR_I;
			drv_q <= DRIVE_CLK_I;
			pon_q <= 1'b0;
			mm_tick_q <= drv_rise && mm_done; // R14
			if (drv_rise) begin
				ppm_cnt_q <= mm_done ? 16'h0000 : ppm_cnt_q + 16'h0001;
			end
		end
	end

	// ***************************************************
	// Limits
	// ***************************************************
	logic inlet_dly_exp, inlet_stat_exp, dlv_dly_exp;
	logic vert_exp, dlv_stat_exp, front_jam, rear_jam;

	wire [16:0] half_len = {2'b00, len_q[15:1]};
	wire [16:0] vert_sum = half_len + sjm_pkg::VERT_MARGIN_MM;
	// Short paper would give a negative feed; clamp to 1 mm
	wire [16:0] vert_mm = vert_sum > sjm_pkg::VERT_PATH_MM ?
		vert_sum - sjm_pkg::VERT_PATH_MM : 17'h00001;
	wire [31:0] inlet_mm = {16'h0000, len_q} + {16'h0000, 1'b0, len_q[15:1]};

	sjm_limit #(.W(32)) u_inlet_dly (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.start_i(inlet_rise),
		.stop_i(first_rise),
		.tick_i(1'b1),
		.limit_i(32'(INLET_DLY_CYC)),
		.expire_o(inlet_dly_exp)
	); // R02
	sjm_limit #(.W(32)) u_inlet_stat (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.start_i(first_rise),
		.stop_i(1'b0),
		.tick_i(mm_tick_q),
		.limit_i(inlet_mm),
		.expire_o(inlet_stat_exp)
	); // R03
	sjm_limit #(.W(32)) u_dlv_dly (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.start_i(top_rise),
		.stop_i(dlv_rise),
		.tick_i(1'b1),
		.limit_i(32'(DLV_DLY_CYC)),
		.expire_o(dlv_dly_exp)
	); // R05
	sjm_limit #(.W(32)) u_vert (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.start_i(dlv_rise),
		.stop_i(vert_fall),
		.tick_i(mm_tick_q),
		.limit_i({15'h0000, vert_mm}),
		.expire_o(vert_exp)
	); // R06
	sjm_limit #(.W(32)) u_dlv_stat (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.start_i(dlv_rise),
		.stop_i(dlv_fall),
		.tick_i(mm_tick_q),
		.limit_i({16'h0000, dlv_q}),
		.expire_o(dlv_stat_exp)
	); // R07
	sjm_stitch #(.WIN(STITCH_CYC)) u_front (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.cw_i(FRONT_STITCHER_MOTOR_CW_I),
		.ccw_i(FRONT_STITCHER_MOTOR_CCW_I),
		.home_i(FRONT_STITCHER_HOME_SENSOR_I),
		.jam_o(front_jam)
	);
	sjm_stitch #(.WIN(STITCH_CYC)) u_rear (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.cw_i(REAR_STITCHER_MOTOR_CW_I),
		.ccw_i(REAR_STITCHER_MOTOR_CCW_I),
		.home_i(REAR_STITCHER_HOME_SENSOR_I),
		.jam_o(rear_jam)
	);

	// ***************************************************
	// Detection
	// ***************************************************
	wire [2:0] sel_mask =
		(single || size == sjm_pkg::SIZE_LARGE) ? 3'h1 : // R04
		size == sjm_pkg::SIZE_B4 ? 3'h3 : 3'h7;
	wire [2:0] paper = {THIRD_PAPER_SENSOR_I, SECOND_PAPER_SENSOR_I,
		FIRST_PAPER_SENSOR_I};
	wire any_path = |paper || VERTICAL_PATH_SENSOR_I || DELIVERY_SENSOR_I;
	wire doors_open = FRONT_DOOR_SENSOR_I || OUTLET_COVER_SENSOR_I ||
		INLET_COVER_SENSOR_I;
	wire door_jam = run && doors_open; // R09
	wire pon_jam = pon_q && any_path; // R08
	wire stat_jam = inlet_stat_exp && |(paper & sel_mask); // R03
	wire vert_jam = vert_exp && VERTICAL_PATH_SENSOR_I; // R06
	wire saddle_jam = PUSH_START_I && !POSITIONING_PLATE_PAPER_SENSOR_I;
	wire staple_jam = front_jam || rear_jam; // R10
	wire det = door_jam || pon_jam || inlet_dly_exp || stat_jam ||
		dlv_dly_exp || vert_jam || dlv_stat_exp || staple_jam ||
		saddle_jam;
	wire [3:0] det_code =
		door_jam ? sjm_pkg::JAM_DOOR :
		pon_jam ? sjm_pkg::JAM_POWER_ON :
		inlet_dly_exp ? sjm_pkg::JAM_INLET_DLY :
		stat_jam ? sjm_pkg::JAM_INLET_STAT :
		dlv_dly_exp ? sjm_pkg::JAM_DLV_DLY :
		vert_jam ? sjm_pkg::JAM_VERT_STAT :
		dlv_stat_exp ? sjm_pkg::JAM_DLV_STAT :
		staple_jam ? sjm_pkg::JAM_STAPLE : sjm_pkg::JAM_SADDLE; // R12

	// ***************************************************
	// Jam latch and door-close recheck
	// ***************************************************
	logic door_seen_q;
	// Recheck only after doors were opened during a jam
	wire recheck = JAM_O && door_seen_q && !doors_open;

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			JAM_O <= 1'b0;
			JAM_CODE_O <= sjm_pkg::JAM_NONE;
			door_seen_q <= 1'b0;
		end else begin
			// New detection wins over a clearing recheck
			if (det) begin // R01
				JAM_O <= 1'b1;
				JAM_CODE_O <= det_code;
			end else if (recheck && VERTICAL_PATH_SENSOR_I) begin // R13
				JAM_O <= 1'b1;
				JAM_CODE_O <= sjm_pkg::JAM_REMOVAL;
			end else if (recheck) begin // R15
				JAM_O <= 1'b0;
				JAM_CODE_O <= sjm_pkg::JAM_NONE;
			end
			if (recheck) door_seen_q <= 1'b0;
			else if (JAM_O && doors_open) door_seen_q <= 1'b1;
		end
	end

	// ***************************************************
	// Checks
	// ***************************************************
	property p_report;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		det |=> JAM_O && JAM_CODE_O != sjm_pkg::JAM_NONE;
	endproperty
	a_report: assert property (p_report) // R01
		else $error("detected jam not reported");
	property p_door;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		run && doors_open |=> JAM_O && JAM_CODE_O == sjm_pkg::JAM_DOOR;
	endproperty
	a_door: assert property (p_door) // R09
		else $error("door open in operation not flagged");
	property p_power;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		pon_q && any_path |=> JAM_O;
	endproperty
	a_power: assert property (p_power) // R08
		else $error("power-on paper not flagged");
	property p_hold;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		JAM_O && !recheck |=> JAM_O && ($stable(JAM_CODE_O) || $past(det));
	endproperty
	a_hold: assert property (p_hold) // R15
		else $error("jam dropped without recheck");
	property p_clear;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		recheck && !VERTICAL_PATH_SENSOR_I && !det |=> !JAM_O;
	endproperty
	a_clear: assert property (p_clear) // R15
		else $error("clear path recheck did not release jam");
	property p_removal;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		recheck && VERTICAL_PATH_SENSOR_I && !det
			|=> JAM_O && JAM_CODE_O == sjm_pkg::JAM_REMOVAL;
	endproperty
	a_removal: assert property (p_removal) // R13
		else $error("faulty removal not reasserted");
	property p_saddle;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		PUSH_START_I && !POSITIONING_PLATE_PAPER_SENSOR_I |=> JAM_O;
	endproperty
	a_saddle: assert property (p_saddle) // R12
		else $error("saddle feed delay not flagged");
	property p_single;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		inlet_stat_exp && single && !FIRST_PAPER_SENSOR_I && !JAM_O
			&& !door_jam && !pon_jam && !inlet_dly_exp && !dlv_dly_exp
			&& !vert_jam && !dlv_stat_exp && !staple_jam && !saddle_jam
			|=> !JAM_O;
	endproperty
	a_single: assert property (p_single) // R04
		else $error("single detection checked other sensors");
	property p_vert;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		vert_exp && VERTICAL_PATH_SENSOR_I |=> JAM_O;
	endproperty
	a_vert: assert property (p_vert) // R06
		else $error("vertical path stationary not flagged");
	// A released jam must never leave a stale code behind
	property p_idle_code;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		!JAM_O |-> JAM_CODE_O == sjm_pkg::JAM_NONE;
	endproperty
	a_idle_code: assert property (p_idle_code) // R15
		else $error("jam code without jam");
	property p_read;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		RD_I && ADDR_I == sjm_pkg::REG_STAT |=> RDATA_O == $past(stat_word);
	endproperty
	a_read: assert property (p_read)
		else $error("status read mismatch");
endmodule

// [testbench/sjm_host_model.sv]
/*
 * Behavioural host copier controller on the jam output.
 * Assumes the monitor's clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
module sjm_host_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic jam_i,
	output logic halt_o
);
	// Copying halts for as long as a jam is reported
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			halt_o <= 1'b0;
		end else begin
			halt_o <= jam_i;
		end
	end
endmodule

// [testbench/saddle_jam_monitor_tb_top.sv]
/*
 * Self-checking bench of the saddle jam monitor with a host model.
 * Assumes short limit parameters and one or two drive pulses per millimetre.
 */
`timescale 1ns/1ps
module saddle_jam_monitor_tb_top;
	// ****************************************
	// Signals and instances
	// ****************************************
	localparam int ID = 20;
	localparam int SC = 10;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	// Paper present at power-on
	logic s1 = 1'b1, s2 = 1'b0, s3 = 1'b0, inl = 1'b0, vert = 1'b0;
	logic dlv = 1'b0, ptop = 1'b0, ppos = 1'b0, push = 1'b0, dclk = 1'b0;
	logic fdoor = 1'b0, ocov = 1'b0, icov = 1'b0;
	logic fcw = 1'b0, fccw = 1'b0, rcw = 1'b0, rccw = 1'b0;
	logic fhome = 1'b0, rhome = 1'b0;
	logic [15:0] rdata;
	logic [3:0] code;
	logic jam, halt;
	int err_count = 0;
	int checks_done = 0;
	always #12.5 clk = ~clk;
	sjm_monitor #(.INLET_DLY_CYC(ID), .DLV_DLY_CYC(ID), .STITCH_CYC(SC))
	i_dut (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.FINISHER_INLET_SENSOR_I(inl), .FIRST_PAPER_SENSOR_I(s1),
		.SECOND_PAPER_SENSOR_I(s2), .THIRD_PAPER_SENSOR_I(s3),
		.VERTICAL_PATH_SENSOR_I(vert), .DELIVERY_SENSOR_I(dlv),
		.PUSHER_TOP_SENSOR_I(ptop), .POSITIONING_PLATE_PAPER_SENSOR_I(ppos),
		.PUSH_START_I(push), .FRONT_DOOR_SENSOR_I(fdoor),
		.OUTLET_COVER_SENSOR_I(ocov), .INLET_COVER_SENSOR_I(icov),
		.DRIVE_CLK_I(dclk), .FRONT_STITCHER_MOTOR_CW_I(fcw),
		.FRONT_STITCHER_MOTOR_CCW_I(fccw), .REAR_STITCHER_MOTOR_CW_I(rcw),
		.REAR_STITCHER_MOTOR_CCW_I(rccw), .FRONT_STITCHER_HOME_SENSOR_I(fhome),
		.REAR_STITCHER_HOME_SENSOR_I(rhome), .JAM_O(jam), .JAM_CODE_O(code));
	sjm_host_model i_host (.clk_i(clk), .rst_i(rst), .jam_i(jam),
		.halt_o(halt));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		cyc(1);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		cyc(1);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
		cyc(1);
		addr <= a;
		rd <= 1'b1;
		cyc(1);
		rd <= 1'b0;
		#1;
		chk("rdata", rdata, exp);
	endtask
	task automatic jchk(input logic [3:0] c);
		@(negedge clk);
		chk("jam", {11'h000, jam, code}, {11'h000, c != 4'h0, c});
	endtask
	task automatic wj(input int mx, input logic [3:0] c);
		for (int i = 0; i < mx && jam !== 1'b1; i++) @(negedge clk);
		jchk(c);
	endtask
	task automatic feed(input int n);
		repeat (n) begin
			cyc(1);
			dclk <= 1'b1;
			cyc(1);
			dclk <= 1'b0;
		end
	endtask
	// Jam must hold, then a door cycle with a clear path releases it
	task automatic clr(input logic [3:0] c);
		cyc(5);
		jchk(c);
		chk("halt", {15'h0000, halt}, 16'h0001);
		cyc(1);
		fdoor <= 1'b1;
		cyc(3);
		fdoor <= 1'b0;
		cyc(6);
		jchk(4'h0);
	endtask
	task automatic stat_case(input logic [15:0] ct, input logic [2:0] s,
		input logic [3:0] c);
		wr_reg(sjm_pkg::REG_CTRL, ct);
		cyc(1);
		s1 <= 1'b1;
		cyc(1);
		{s3, s2, s1} <= s;
		feed(26);
		jchk(4'h0);
		feed(8);
		jchk(c);
		cyc(1);
		{s3, s2, s1} <= 3'b000;
		if (c != 4'h0) clr(c);
	endtask
	task automatic stitch(input logic fr, input logic ccw, input int dly,
		input logic [3:0] c);
		cyc(1);
		{fhome, rhome} <= ccw ? 2'b00 : {fr, ~fr};
		cyc(2);
		{fcw, fccw, rcw, rccw} <= fr ? {~ccw, ccw, 2'b00} : {2'b00, ~ccw, ccw};
		{fhome, rhome} <= 2'b00;
		cyc(dly);
		{fhome, rhome} <= {fr, ~fr};
		cyc(SC + 6);
		jchk(c);
		cyc(1);
		{fcw, fccw, rcw, rccw} <= 4'h0;
		cyc(1);
		{fhome, rhome} <= 2'b00;
		if (c != 4'h0) clr(c);
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		conclude;
	end
	initial begin
		cyc(4);
		rst <= 1'b0;
		wj(4, 4'h6);
		cyc(1);
		s1 <= 1'b0;
		clr(4'h6);
		chk("halt", {15'h0000, halt}, 16'h0000);
		rd_reg(sjm_pkg::REG_CTRL, 16'h0000);
		rd_reg(sjm_pkg::REG_LEN, sjm_pkg::LEN_RST);
		rd_reg(sjm_pkg::REG_DLV, sjm_pkg::DLV_RST);
		rd_reg(sjm_pkg::REG_PPM, sjm_pkg::PPM_RST);
		rd_reg(sjm_pkg::REG_STAT, 16'h0000);
		wr_reg(4'h5, 16'hffff);
		rd_reg(4'h5, 16'h0000);
		cyc(1);
		inl <= 1'b1;
		cyc(5);
		s1 <= 1'b1;
		cyc(ID + 10);
		jchk(4'h0);
		cyc(1);
		inl <= 1'b0;
		s1 <= 1'b0;
		cyc(1);
		inl <= 1'b1;
		cyc(ID - 5);
		jchk(4'h0);
		wj(12, 4'h1);
		cyc(1);
		inl <= 1'b0;
		clr(4'h1);
		wr_reg(sjm_pkg::REG_PPM, 16'h0001);
		wr_reg(sjm_pkg::REG_LEN, 16'h0014);
		stat_case(16'h0000, 3'b001, 4'h2);
		stat_case(16'h0000, 3'b100, 4'h0);
		stat_case(16'h0004, 3'b010, 4'h2);
		stat_case(16'h0004, 3'b100, 4'h0);
		stat_case(16'h0008, 3'b100, 4'h2);
		stat_case(16'h000a, 3'b100, 4'h0);
		cyc(1);
		ptop <= 1'b1;
		cyc(ID - 5);
		jchk(4'h0);
		wj(12, 4'h3);
		cyc(1);
		ptop <= 1'b0;
		clr(4'h3);
		wr_reg(sjm_pkg::REG_LEN, 16'h0190);
		wr_reg(sjm_pkg::REG_DLV, 16'h03e8);
		cyc(1);
		vert <= 1'b1;
		cyc(1);
		dlv <= 1'b1;
		feed(116);
		jchk(4'h0);
		feed(8);
		jchk(4'h4);
		cyc(1);
		vert <= 1'b0;
		dlv <= 1'b0;
		clr(4'h4);
		wr_reg(sjm_pkg::REG_DLV, 16'h000a);
		for (int p = 1; p < 3; p++) begin
			wr_reg(sjm_pkg::REG_PPM, 16'(p));
			cyc(1);
			dlv <= 1'b1;
			feed(10 * p - 3);
			jchk(4'h0);
			feed(6);
			jchk(4'h5);
			cyc(1);
			dlv <= 1'b0;
			clr(4'h5);
		end
		for (int k = 0; k < 3; k++) begin
			wr_reg(sjm_pkg::REG_CTRL, 16'h0001);
			cyc(1);
			{icov, ocov, fdoor} <= 3'b001 << k;
			cyc(3);
			jchk(4'h7);
			rd_reg(sjm_pkg::REG_STAT, 16'h0017);
			wr_reg(sjm_pkg::REG_CTRL, 16'h0000);
			cyc(1);
			{icov, ocov, fdoor} <= 3'b000;
			cyc(6);
			jchk(4'h0);
		end
		cyc(1);
		ocov <= 1'b1;
		cyc(4);
		jchk(4'h0);
		cyc(1);
		ocov <= 1'b0;
		stitch(1'b1, 1'b0, 4, 4'h0);
		stitch(1'b1, 1'b0, 15, 4'h8);
		stitch(1'b0, 1'b0, 15, 4'h8);
		stitch(1'b0, 1'b1, 4, 4'h8);
		stitch(1'b0, 1'b1, 15, 4'h0);
		stitch(1'b1, 1'b1, 4, 4'h8);
		cyc(1);
		ppos <= 1'b1;
		push <= 1'b1;
		cyc(1);
		push <= 1'b0;
		ppos <= 1'b0;
		cyc(3);
		jchk(4'h0);
		cyc(1);
		push <= 1'b1;
		cyc(1);
		push <= 1'b0;
		cyc(3);
		jchk(4'h9);
		cyc(1);
		vert <= 1'b1;
		fdoor <= 1'b1;
		cyc(3);
		fdoor <= 1'b0;
		cyc(6);
		jchk(4'ha);
		cyc(1);
		vert <= 1'b0;
		clr(4'ha);
		conclude;
	end
endmodule
